// ==== sleep_wake_pkg.sv ====
// Constants, types and register map of the end-device sleep and wake sequencer
// Operation
// [R1] Mode 2, analog on: pushbutton wake gives reset, target set-up, analog report.
// [R2] Awake in mode 2 or 3: pushbutton press is reported only if reporting is on.
// [R3] Mode 2, analog off, key on, interval set: timer wake then key report.
// [R4] Mode 2, both off: pushbutton wake only, set-up, sleep one second later.
// [R5] Host serial bytes taken while awake are forwarded to the target.
// [R6] Once the target is set the node sleeps by itself.
// [R7] Mode 3: the interval timer never wakes the node.
// [R8] Mode 3, key on: pushbutton wake gives reset, set-up, key report.
// [R9] Mode 3, key off: set-up, then sleep one second after it completes.
// [R10] Host wakes node, awaits acknowledge, sends escape within the one-second window. Code: no serial wake or escape handling.
// [R11] Timed report order: wake, reset, join, set-up, send, acknowledge, standby, sleep.
// [R12] Host serial link runs at any rate from 9600 to 230400 bit/s.
// [R13] Modes 2 and 3 wake on pushbutton low level, not on an edge.
// [R14] Interval setting in seconds sets the timer wake period.
// [R15] Ok and error outputs high while asleep, low after waking.
// [R16] Interval timer restarts from zero on every sleep entry.
package sleep_wake_pkg;
    localparam int CLK_HZ       = 250_000_000;
    localparam int STANDBY_S    = 1;
    localparam int STANDBY_CYC  = CLK_HZ * STANDBY_S;
    localparam int BAUD_MIN_BPS = 9600;
    localparam int BAUD_MAX_BPS = 230400;
    localparam logic [15:0] BAUD_DIV_MAX = 16'(CLK_HZ / BAUD_MIN_BPS);
    localparam logic [15:0] BAUD_DIV_MIN = 16'(CLK_HZ / BAUD_MAX_BPS);

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [4:0] ADR_CTRL     = 5'h00;
    localparam logic [4:0] ADR_INTERVAL = 5'h04;
    localparam logic [4:0] ADR_BAUD     = 5'h08;
    localparam logic [4:0] ADR_STATE    = 5'h0c;
    localparam logic [4:0] ADR_IRQ_STAT = 5'h10;
    localparam logic [4:0] ADR_IRQ_MASK = 5'h14;

    localparam logic [15:0] INTERVAL_RST = 16'h0000;
    localparam logic [3:0]  IRQ_MASK_RST = 4'h0;
    localparam int IRQ_W     = 4;
    localparam int IRQ_WAKE  = 0;
    localparam int IRQ_ACK   = 1;
    localparam int IRQ_OVR   = 2;
    localparam int IRQ_SLEEP = 3;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic key_en;
        logic adc_en;
        logic mode3;
        logic run;
    } ctrl_t;
    localparam ctrl_t CTRL_RST = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_SLEEP = 3'h1,
        ST_NRST  = 3'h3,
        ST_JOIN  = 3'h2,
        ST_TGT   = 3'h6,
        ST_SEND  = 3'h7,
        ST_ACKW  = 3'h5,
        ST_STBY  = 3'h4
    } seq_state_t;

    typedef enum logic [1:0] {
        RPT_NONE   = 2'h0,
        RPT_ANALOG = 2'h1,
        RPT_KEY    = 2'h2,
        RPT_SERIAL = 2'h3
    } report_t;

    typedef struct packed {
        report_t     kind;
        logic [15:0] data;
    } send_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'h0,
        RX_START = 2'h1,
        RX_DATA  = 2'h3,
        RX_STOP  = 2'h2
    } rx_state_t;
endpackage : sleep_wake_pkg

// ==== host_uart_rx.sv ====
// Host serial receiver with programmable bit divisor
module host_uart_rx import sleep_wake_pkg::*; #(
    parameter int DATA_W = 8
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              rx,
    input  wire logic [15:0]       div,
    output logic                   byte_valid,
    output logic [DATA_W-1:0]      byte_data,
    output logic                   frame_err
);
    localparam int IDX_W = (DATA_W > 1) ? $clog2(DATA_W) : 1;

    rx_state_t          st_r, st_nxt;
    logic [15:0]        cnt_r, cnt_nxt;
    logic [IDX_W-1:0]   idx_r, idx_nxt;
    logic [DATA_W-1:0]  sh_r, sh_nxt;
    logic               vld_r, vld_nxt, fe_r, fe_nxt;

    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        idx_nxt = idx_r;
        sh_nxt  = sh_r;
        vld_nxt = 1'b0;
        fe_nxt  = 1'b0;
        case (st_r)
            RX_IDLE: begin
                if (!rx) begin
                    st_nxt  = RX_START;
                    cnt_nxt = {1'b0, div[15:1]};
                end
            end
            RX_START: begin
                if (cnt_r == 16'h0000) begin
                    // Glitch shorter than half a bit is dropped
                    st_nxt  = rx ? RX_IDLE : RX_DATA;
                    cnt_nxt = div - 16'h0001; // [R12]
                    idx_nxt = '0;
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            RX_DATA: begin
                if (cnt_r == 16'h0000) begin
                    sh_nxt  = {rx, sh_r[DATA_W-1:1]};
                    cnt_nxt = div - 16'h0001;
                    if (idx_r == IDX_W'(DATA_W - 1)) begin
                        st_nxt = RX_STOP;
                    end else begin
                        idx_nxt = idx_r + 1'b1;
                    end
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            RX_STOP: begin
                if (cnt_r == 16'h0000) begin
                    st_nxt  = RX_IDLE;
                    vld_nxt = rx;
                    fe_nxt  = !rx;
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            default: st_nxt = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r  <= RX_IDLE;
            cnt_r <= 16'h0000;
            idx_r <= '0;
            sh_r  <= '0;
            vld_r <= 1'b0;
            fe_r  <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            idx_r <= idx_nxt;
            sh_r  <= sh_nxt;
            vld_r <= vld_nxt;
            fe_r  <= fe_nxt;
        end
    end

    assign byte_valid = vld_r;
    assign byte_data  = sh_r;
    assign frame_err  = fe_r;
endmodule : host_uart_rx

// ==== end_device_sleep_wake.sv ====
// End-device sleep, wake and report sequencer with Avalon-MM registers
module end_device_sleep_wake import sleep_wake_pkg::*; #(
    parameter int CYC_PER_SEC = STANDBY_CYC
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic [4:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic             IRQ,
    input  wire logic        KEY_N,
    input  wire logic        UART_RX,
    output logic             OK,
    output logic             ERROR,
    output logic             STATUS,
    output logic             NODE_RST,
    output logic             JOIN_REQ,
    input  wire logic        JOIN_DONE,
    output logic             TGT_REQ,
    input  wire logic        TGT_DONE,
    input  wire logic [9:0]  ADC_VALUE,
    output logic             SEND_VALID,
    output send_t            SEND_REQ,
    input  wire logic        TGT_ACK,
    input  wire logic        TGT_NAK
);
    localparam int PRE_W = $clog2(CYC_PER_SEC + 1);

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    function automatic logic [15:0] clamp_div(input logic [15:0] d);
        // Out-of-range divisors would leave the supported rate band
        if (d < BAUD_DIV_MIN) clamp_div = BAUD_DIV_MIN;
        else if (d > BAUD_DIV_MAX) clamp_div = BAUD_DIV_MAX;
        else clamp_div = d;
    endfunction : clamp_div

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a change counts once second and third stage agree
    logic [2:0] key_s_r, rx_s_r;
    logic       key_lvl_r, key_lvl_nxt, key_prev_r, rx_lvl_r, rx_lvl_nxt;

    always_comb begin
        key_lvl_nxt = (key_s_r[1] == key_s_r[2]) ? key_s_r[2] : key_lvl_r;
        rx_lvl_nxt  = (rx_s_r[1] == rx_s_r[2]) ? rx_s_r[2] : rx_lvl_r;
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            key_s_r    <= 3'h7;
            rx_s_r     <= 3'h7;
            key_lvl_r  <= 1'b1;
            key_prev_r <= 1'b1;
            rx_lvl_r   <= 1'b1;
        end else begin
            key_s_r    <= {key_s_r[1:0], KEY_N};
            rx_s_r     <= {rx_s_r[1:0], UART_RX};
            key_lvl_r  <= key_lvl_nxt;
            key_prev_r <= key_lvl_r;
            rx_lvl_r   <= rx_lvl_nxt;
        end
    end

    logic       key_low, key_fall, rx_valid;
    logic [7:0] rx_data;
    logic [15:0] baud_r;

    assign key_low  = !key_lvl_r;
    assign key_fall = key_prev_r && !key_lvl_r;

    host_uart_rx #(.DATA_W(8)) u_rx (
        .clk        (CORE_CLK),
        .rst_n      (RST_N),
        .rx         (rx_lvl_r),
        .div        (baud_r),
        .byte_valid (rx_valid),
        .byte_data  (rx_data),
        .frame_err  ()
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    ctrl_t      ctrl_r;
    logic [15:0] interval_r;
    seq_state_t st_r, st_nxt;
    logic [PRE_W-1:0] pre_r, pre_nxt;
    logic [15:0] secs_r, secs_nxt;
    logic       boot_r, boot_nxt, ser_pend_r, ser_pend_nxt, key_pend_r, key_pend_nxt;
    logic [7:0] ser_data_r, ser_data_nxt;
    logic       sec_tick, tmr_ok, timer_due, awake_set, ovr_ev;
    send_t      send_nxt;
    report_t    wake_rpt;

    assign sec_tick  = (pre_r == PRE_W'(CYC_PER_SEC - 1));
    assign tmr_ok    = ctrl_r.run && !ctrl_r.mode3 && (interval_r != 16'h0000)
                       && (ctrl_r.adc_en || ctrl_r.key_en); // [R7] [R3] [R4]
    assign timer_due = tmr_ok && sec_tick
                       && (({1'b0, secs_r} + 17'h00001) >= {1'b0, interval_r}); // [R14]
    assign awake_set = (st_r == ST_SEND) || (st_r == ST_ACKW) || (st_r == ST_STBY);
    assign wake_rpt  = (ctrl_r.adc_en && !ctrl_r.mode3) ? RPT_ANALOG :
                       ctrl_r.key_en ? RPT_KEY : RPT_NONE; // [R1] [R3] [R8]

    always_comb begin
        st_nxt       = st_r;
        boot_nxt     = boot_r;
        send_nxt     = SEND_REQ;
        ser_pend_nxt = ser_pend_r;
        ser_data_nxt = ser_data_r;
        key_pend_nxt = key_pend_r;
        ovr_ev       = 1'b0;
        case (st_r)
            ST_IDLE: begin
                if (ctrl_r.run) begin
                    st_nxt   = ST_NRST;
                    boot_nxt = 1'b1;
                end
            end
            ST_SLEEP: begin
                if (!ctrl_r.run) st_nxt = ST_IDLE;
                else if (key_low) st_nxt = ST_NRST; // [R13]
                else if (timer_due) st_nxt = ST_NRST; // [R11]
            end
            ST_NRST: st_nxt = ST_JOIN;
            ST_JOIN: if (JOIN_DONE) st_nxt = ST_TGT;
            ST_TGT: begin
                if (TGT_DONE) begin
                    boot_nxt = 1'b0;
                    if (boot_r) st_nxt = ST_SLEEP; // [R6]
                    else if (wake_rpt == RPT_NONE) st_nxt = ST_STBY; // [R4] [R9]
                    else begin
                        st_nxt        = ST_SEND;
                        send_nxt.kind = wake_rpt;
                        send_nxt.data = (wake_rpt == RPT_ANALOG) ? {6'h00, ADC_VALUE}
                                                                 : {15'h0000, key_low};
                    end
                end
            end
            ST_SEND: st_nxt = ST_ACKW;
            ST_ACKW: if (TGT_ACK || TGT_NAK) st_nxt = ST_STBY; // [R11]
            ST_STBY: begin
                if (!ctrl_r.run) st_nxt = ST_IDLE;
                else if (ser_pend_r) begin
                    st_nxt        = ST_SEND; // [R5]
                    ser_pend_nxt  = 1'b0;
                    send_nxt.kind = RPT_SERIAL;
                    send_nxt.data = {8'h00, ser_data_r};
                end else if (key_pend_r) begin
                    st_nxt        = ST_SEND; // [R2]
                    key_pend_nxt  = 1'b0;
                    send_nxt.kind = RPT_KEY;
                    send_nxt.data = {15'h0000, 1'b1};
                end else if (!key_low && sec_tick) st_nxt = ST_SLEEP; // [R9] [R11]
            end
            default: st_nxt = ST_IDLE;
        endcase
        // Press while awake; set wins over the take above
        if (awake_set && key_fall && ctrl_r.key_en) key_pend_nxt = 1'b1; // [R2]
        // Single holding byte; a byte that finds it full is dropped and flagged
        if (rx_valid && awake_set) begin
            if (ser_pend_nxt) ovr_ev = 1'b1;
            else begin
                ser_pend_nxt = 1'b1; // [R5]
                ser_data_nxt = rx_data;
            end
        end
        if (st_nxt == ST_IDLE) begin
            ser_pend_nxt = 1'b0;
            key_pend_nxt = 1'b0;
        end
    end

    // One prescaler serves both the interval and the standby second
    always_comb begin
        pre_nxt  = sec_tick ? '0 : pre_r + 1'b1;
        secs_nxt = secs_r;
        if ((st_r == ST_SLEEP) && sec_tick) secs_nxt = secs_r + 16'h0001;
        if (st_nxt != st_r || (st_r == ST_STBY && key_low)) pre_nxt = '0;
        if (st_nxt == ST_SLEEP && st_r != ST_SLEEP) secs_nxt = 16'h0000; // [R16]
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_r       <= ST_IDLE;
            boot_r     <= 1'b0;
            pre_r      <= '0;
            secs_r     <= 16'h0000;
            ser_pend_r <= 1'b0;
            ser_data_r <= 8'h00;
            key_pend_r <= 1'b0;
            SEND_REQ   <= '0;
            SEND_VALID <= 1'b0;
            NODE_RST   <= 1'b0;
            JOIN_REQ   <= 1'b0;
            TGT_REQ    <= 1'b0;
            OK         <= 1'b0;
            ERROR      <= 1'b0;
            STATUS     <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            boot_r     <= boot_nxt;
            pre_r      <= pre_nxt;
            secs_r     <= secs_nxt;
            ser_pend_r <= ser_pend_nxt;
            ser_data_r <= ser_data_nxt;
            key_pend_r <= key_pend_nxt;
            SEND_REQ   <= send_nxt;
            SEND_VALID <= (st_nxt == ST_SEND);
            NODE_RST   <= (st_nxt == ST_NRST);
            JOIN_REQ   <= (st_nxt == ST_JOIN);
            TGT_REQ    <= (st_nxt == ST_TGT);
            OK         <= (st_nxt == ST_SLEEP); // [R15]
            ERROR      <= (st_nxt == ST_SLEEP); // [R15]
            STATUS     <= (st_nxt == ST_SLEEP) || (st_nxt == ST_SEND) ||
                          (st_nxt == ST_ACKW) || (st_nxt == ST_STBY);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: answers in the second cycle of every request
    logic        ack_r, ack_nxt, wr_go;
    logic [31:0] rmux, rdata_nxt;
    ctrl_t       ctrl_nxt;
    logic [15:0] interval_nxt, baud_nxt;
    logic [IRQ_W-1:0] istat_r, istat_nxt, imask_r, imask_nxt, ev;

    assign ev = {st_nxt == ST_SLEEP && st_r != ST_SLEEP, ovr_ev,
                 st_r == ST_ACKW && st_nxt == ST_STBY,
                 st_r == ST_SLEEP && st_nxt == ST_NRST};

    always_comb begin
        ack_nxt      = (AVS_READ || AVS_WRITE) && !ack_r;
        wr_go        = ack_r && AVS_WRITE;
        ctrl_nxt     = ctrl_r;
        interval_nxt = interval_r;
        baud_nxt     = baud_r;
        imask_nxt    = imask_r;
        istat_nxt    = istat_r;
        case (AVS_ADDRESS)
            ADR_CTRL:     rmux = {28'h0000000, ctrl_r};
            ADR_INTERVAL: rmux = {16'h0000, interval_r};
            ADR_BAUD:     rmux = {16'h0000, baud_r};
            ADR_STATE:    rmux = {28'h0000000, st_r == ST_SLEEP, st_r};
            ADR_IRQ_STAT: rmux = {28'h0000000, istat_r};
            ADR_IRQ_MASK: rmux = {28'h0000000, imask_r};
            default:      rmux = 32'h00000000;
        endcase
        rdata_nxt = (ack_nxt && AVS_READ) ? rmux : AVS_READDATA;
        if (wr_go && AVS_BYTEENABLE[0]) begin
            case (AVS_ADDRESS)
                ADR_CTRL:     ctrl_nxt = AVS_WRITEDATA[3:0];
                ADR_IRQ_STAT: istat_nxt = istat_r & ~AVS_WRITEDATA[IRQ_W-1:0];
                ADR_IRQ_MASK: imask_nxt = AVS_WRITEDATA[IRQ_W-1:0];
                default: ;
            endcase
        end
        if (wr_go && AVS_ADDRESS == ADR_INTERVAL)
            interval_nxt = merge16(interval_r, AVS_WRITEDATA, AVS_BYTEENABLE); // [R14]
        if (wr_go && AVS_ADDRESS == ADR_BAUD)
            baud_nxt = clamp_div(merge16(baud_r, AVS_WRITEDATA, AVS_BYTEENABLE)); // [R12]
        // Event in the clearing cycle survives
        istat_nxt = istat_nxt | ev;
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_r           <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h00000000;
            ctrl_r          <= CTRL_RST;
            interval_r      <= INTERVAL_RST;
            baud_r          <= BAUD_DIV_MAX;
            istat_r         <= '0;
            imask_r         <= IRQ_MASK_RST;
            IRQ             <= 1'b0;
        end else begin
            ack_r           <= ack_nxt;
            AVS_WAITREQUEST <= !ack_nxt;
            AVS_READDATA    <= rdata_nxt;
            ctrl_r          <= ctrl_nxt;
            interval_r      <= interval_nxt;
            baud_r          <= baud_nxt;
            istat_r         <= istat_nxt;
            imask_r         <= imask_nxt;
            IRQ             <= |(istat_nxt & imask_nxt);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    property p_wake_level;
        st_r == ST_SLEEP && ctrl_r.run && key_low |=> st_r == ST_NRST && NODE_RST
            ##1 st_r == ST_JOIN && JOIN_REQ;
    endproperty
    a_wake_level: assert property (p_wake_level) else $error("no wake on key low"); // [R13]
    property p_mode3_no_timer;
        st_r == ST_SLEEP && ctrl_r.mode3 && !key_low && ctrl_r.run |=> st_r == ST_SLEEP;
    endproperty
    a_mode3_no_timer: assert property (p_mode3_no_timer) else $error("mode3 timer wake"); // [R7]
    property p_timer_wake;
        timer_due && st_r == ST_SLEEP |=> st_r == ST_NRST;
    endproperty
    a_timer_wake: assert property (p_timer_wake) else $error("timer wake missed"); // [R14]
    property p_analog_rpt;
        st_r == ST_TGT && TGT_DONE && !boot_r && ctrl_r.adc_en && !ctrl_r.mode3
            |=> SEND_VALID && SEND_REQ.kind == RPT_ANALOG ##1 !SEND_VALID;
    endproperty
    a_analog_rpt: assert property (p_analog_rpt) else $error("analog report missing"); // [R1]
    property p_key_rpt;
        st_r == ST_TGT && TGT_DONE && !boot_r && ctrl_r.key_en
            && (ctrl_r.mode3 || !ctrl_r.adc_en) |=> SEND_VALID && SEND_REQ.kind == RPT_KEY;
    endproperty
    a_key_rpt: assert property (p_key_rpt) else $error("key report missing"); // [R8]
    property p_no_rpt;
        st_r == ST_TGT && TGT_DONE && !boot_r && wake_rpt == RPT_NONE
            |=> st_r == ST_STBY && !SEND_VALID;
    endproperty
    a_no_rpt: assert property (p_no_rpt) else $error("unexpected report"); // [R9]
    property p_boot_sleep;
        st_r == ST_TGT && TGT_DONE && boot_r |=> st_r == ST_SLEEP && OK;
    endproperty
    a_boot_sleep: assert property (p_boot_sleep) else $error("no sleep after set-up"); // [R6]
    property p_ack_stby;
        st_r == ST_ACKW && (TGT_ACK || TGT_NAK) |=> st_r == ST_STBY;
    endproperty
    a_ack_stby: assert property (p_ack_stby) else $error("ack not followed by standby"); // [R11]
    property p_serial_fwd;
        st_r == ST_STBY && ser_pend_r && ctrl_r.run
            |=> SEND_VALID && SEND_REQ.kind == RPT_SERIAL && SEND_REQ.data[7:0] == $past(ser_data_r);
    endproperty
    a_serial_fwd: assert property (p_serial_fwd) else $error("serial byte not sent"); // [R5]
    property p_wake_leds;
        st_r == ST_SLEEP ##1 st_r == ST_NRST |=> !OK && !ERROR && STATUS == 1'b0;
    endproperty
    a_wake_leds: assert property (p_wake_leds) else $error("indicators not low on wake"); // [R15]
    property p_sleep_restart;
        st_r != ST_SLEEP && st_nxt == ST_SLEEP |=> secs_r == 16'h0000 && pre_r == '0;
    endproperty
    a_sleep_restart: assert property (p_sleep_restart) else $error("timer not restarted"); // [R16]
    property p_key_awake;
        st_r == ST_STBY && key_pend_r && !ser_pend_r && ctrl_r.run |=> SEND_VALID;
    endproperty
    a_key_awake: assert property (p_key_awake) else $error("awake key not sent"); // [R2]

    c_analog: cover property (SEND_VALID && SEND_REQ.kind == RPT_ANALOG);
    c_serial: cover property (SEND_VALID && SEND_REQ.kind == RPT_SERIAL);
    c_resleep: cover property (st_r == ST_STBY ##1 st_r == ST_SLEEP);
endmodule : end_device_sleep_wake

// ==== target_node_model.sv ====
// Radio target model: answers join and set-up dly + 1 cycles after the request, reports dly + 2 cycles after it
module target_node_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       join_req,
    input  wire logic       tgt_req,
    input  wire logic       send_valid,
    input  wire logic [3:0] dly,
    output logic            join_done,
    output logic            tgt_done,
    output logic            ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    logic       pend;
    // One request at a time, so one shared delay counter
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {cnt, pend, join_done, tgt_done, ack} <= '0;
        end else begin
            {join_done, tgt_done, ack} <= '0;
            if (send_valid) pend <= 1'b1;
            if ((join_req || tgt_req || pend) && !join_done && !tgt_done && !ack) begin
                cnt <= (cnt == dly) ? 4'h0 : cnt + 4'h1;
                if (cnt == dly) {join_done, tgt_done, ack, pend} <= {join_req, tgt_req, pend, 1'b0};
            end
        end
    end
endmodule : target_node_model

// ==== testbench.sv ====
// Self-checking bench for the sleep and wake sequencer
module testbench import sleep_wake_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CPS = 11000;
    logic        CORE_CLK, RST_N, AVS_READ, AVS_WRITE, KEY_N, UART_RX, JOIN_DONE, TGT_DONE;
    logic        TGT_ACK, AVS_WAITREQUEST, IRQ, OK, ERROR, STATUS, NODE_RST, JOIN_REQ, TGT_REQ;
    logic        SEND_VALID;
    logic [4:0]  AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd, tmp, seed = 32'h4f90c8a3;
    logic [9:0]  ADC_VALUE;
    logic [3:0]  dly;
    send_t       SEND_REQ;
    int          miscompares, checks, cyc, n;
    logic [31:0] expq[$];
    end_device_sleep_wake #(.CYC_PER_SEC(CPS)) DUT (.CORE_CLK, .RST_N, .AVS_ADDRESS, .AVS_READ,
        .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE(4'hf), .AVS_READDATA, .AVS_WAITREQUEST, .IRQ,
        .KEY_N, .UART_RX, .OK, .ERROR, .STATUS, .NODE_RST, .JOIN_REQ, .JOIN_DONE, .TGT_REQ,
        .TGT_DONE, .ADC_VALUE, .SEND_VALID, .SEND_REQ, .TGT_ACK, .TGT_NAK(1'b0));
    target_node_model RADIO (.clk(CORE_CLK), .rst_n(RST_N), .join_req(JOIN_REQ), .tgt_req(TGT_REQ),
        .send_valid(SEND_VALID), .dly, .join_done(JOIN_DONE), .tgt_done(TGT_DONE), .ack(TGT_ACK));
    initial begin
        CORE_CLK = 1'b0;
        forever #2 CORE_CLK = ~CORE_CLK;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        {AVS_ADDRESS, AVS_WRITEDATA, AVS_WRITE, AVS_READ} <= {a, d, wr, !wr};
        @(posedge CORE_CLK);
        while (AVS_WAITREQUEST !== 1'b0) @(posedge CORE_CLK);
        rd = AVS_READDATA;
        {AVS_WRITE, AVS_READ} <= 2'h0;
    endtask : bus
    task automatic uart(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            UART_RX <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
            repeat (1085) @(posedge CORE_CLK);
        end
    endtask : uart
    task automatic wait_ok(input logic v);
        n = 0;
        while (OK !== v) begin
            @(posedge CORE_CLK);
            n++;
        end
    endtask : wait_ok
    task automatic wait_sent();
        while (expq.size() != 0) @(posedge CORE_CLK);
    endtask : wait_sent
    ////////////////////////////////////////////////////////////////////////////////////
    // Hang guard and model comparison of every report
    always @(posedge CORE_CLK) begin
        cyc++;
        if (SEND_VALID === 1'b1)
            chk(32'(SEND_REQ), (expq.size() != 0) ? expq.pop_front() : '1);
        if (cyc == 120000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        {AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA, RST_N, ADC_VALUE, dly} = '0;
        {KEY_N, UART_RX} = 2'h3;
        repeat (20) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 5'(i * 4), 32'h0);
            chk(rd, (i == 2) ? 32'h65b9 : 32'h0);
        end
        bus(1'b1, 5'h18, 32'hffff);
        bus(1'b0, 5'h18, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, ADR_BAUD, 32'h0);
        bus(1'b0, ADR_BAUD, 32'h0);
        chk(rd, 32'h43d);
        bus(1'b1, ADR_IRQ_MASK, 32'h1);
        bus(1'b1, ADR_CTRL, 32'h5);
        wait_ok(1'b1);
        chk(32'({ERROR, STATUS}), 32'h3);
        $display("test boot done");
        tmp = rnd();
        {dly, ADC_VALUE} <= {tmp[13:10], tmp[9:0]};
        expq.push_back({14'h0, RPT_ANALOG, 6'h0, tmp[9:0]});
        KEY_N <= 1'b0;
        wait_ok(1'b0);
        chk(32'(ERROR), 32'h0);
        repeat (8) @(posedge CORE_CLK);
        KEY_N <= 1'b1;
        wait_sent();
        while (TGT_ACK !== 1'b1) @(posedge CORE_CLK);
        repeat (3) begin
            expq.push_back({14'h0, RPT_SERIAL, 16'h002b});
            uart(8'h2b);
        end
        wait_sent();
        wait_ok(1'b1);
        chk(32'(IRQ), 32'h1);
        bus(1'b1, ADR_IRQ_STAT, 32'hf);
        repeat (2) @(posedge CORE_CLK);
        chk(32'(IRQ), 32'h0);
        $display("test analog key wake done");
        bus(1'b1, ADR_CTRL, 32'hb);
        bus(1'b1, ADR_INTERVAL, 32'h1);
        repeat (CPS + 100) @(posedge CORE_CLK);
        chk(32'(OK), 32'h1);
        dly <= 4'(rnd());
        expq.push_back({14'h0, RPT_KEY, 16'h1});
        KEY_N <= 1'b0;
        wait_ok(1'b0);
        wait_sent();
        KEY_N <= 1'b1;
        wait_ok(1'b1);
        bus(1'b1, ADR_CTRL, 32'h3);
        KEY_N <= 1'b0;
        wait_ok(1'b0);
        repeat (8) @(posedge CORE_CLK);
        KEY_N <= 1'b1;
        wait_ok(1'b1);
        chk(32'(n > CPS - 20 && n < CPS + 40), 32'h1);
        $display("test mode3 done");
        bus(1'b1, ADR_CTRL, 32'h9);
        expq.push_back({14'h0, RPT_KEY, 16'h0});
        wait_ok(1'b0);
        chk(32'(n > CPS - 40 && n < CPS + 10), 32'h1);
        wait_sent();
        expq.push_back({14'h0, RPT_KEY, 16'h1});
        KEY_N <= 1'b0;
        repeat (8) @(posedge CORE_CLK);
        KEY_N <= 1'b1;
        wait_sent();
        wait_ok(1'b1);
        $display("test timer wake done");
        close_out();
    end
endmodule : testbench
